// ==== logic/csir_pkg.sv ====
// constants for the charger status and interrupt register block
package csir_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CHARGE_STATUS_OFS = 8'h01;
    localparam logic [7:0] REGULATOR_STATUS_OFS = 8'h02;
    localparam logic [7:0] CHARGE_IRQ_MASK_OFS = 8'h03;
    localparam logic [7:0] REGULATOR_IRQ_MASK_OFS = 8'h04;
    localparam logic [7:0] CHARGE_IRQ_ACK_OFS = 8'h05;
    localparam logic [7:0] REGULATOR_IRQ_ACK_OFS = 8'h06;
    localparam logic [7:0] CHARGER_CONFIG_OFS = 8'h07;

    // ------------------------------------------------------------
    // reset values and read answers
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'hff;
    localparam logic [7:0] ACK_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h1b;
    localparam logic [7:0] UNMAPPED_READ = 8'hff;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    // charge status bits set on a rising edge (others follow level)
    localparam logic [7:0] CHG_EDGE_BITS = 8'h21;
    // charge status bits the host may write (timeouts, termination)
    localparam logic [7:0] CHG_WRITABLE_BITS = 8'h1e;
    // regulator status bits set on a rising edge
    localparam logic [7:0] REG_EDGE_BITS = 8'he0;
    // regulator bit that does not exist
    localparam logic [7:0] REG_UNUSED_BIT = 8'h10;
    localparam int CFG_POR_SEL = 7;
    localparam int CFG_RESTART = 6;
    localparam int CFG_FAST_TIMER = 5;
    localparam int CFG_CURRENT_MSB = 4;
    localparam int CFG_CURRENT_LSB = 3;
    localparam int CFG_USB_500 = 2;
    localparam int CFG_USB_ALLOWED = 1;
    localparam int CFG_CHARGE_EN = 0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_KHZ = 125000;
    localparam int unsigned POR_LONG_MS = 1000;
    localparam int unsigned POR_SHORT_MS = 69;
    localparam int unsigned POR_LONG_CYCLES = POR_LONG_MS * CLK_KHZ;
    localparam int unsigned POR_SHORT_CYCLES = POR_SHORT_MS * CLK_KHZ;
    localparam int POR_COUNT_W = 27;

endpackage

// ==== logic/csir_regs.sv ====
// status, mask, acknowledge and charger configuration registers
`timescale 1ns/1ps
// ----------------------------------------------------------------
// What this block does
// - usb flag follows valid usb source
// - adapter flag follows valid adapter source
// - thermal suspend flag set on charge pause
// - termination flag set when charging stops
// - three timeout flags follow their timers
// - battery temperature flag set on fault
// - host writes bits 1-4 only, resets charger
// - unmasked charge status bit drives interrupt
// - power button flag set on press
// - undervoltage flag set below lockout threshold
// - regulator bit four unimplemented everywhere
// - linear regulator flags gated by enable
// - core flag also set when off in low-power
// - regulator rising edge drives interrupt unless masked
// - charge mask blocks bits, resets to ones
// - regulator mask blocks bits, resets to ones
// - charge acknowledge blocks bit from pin
// - regulator acknowledge blocks bit from pin
// - acknowledges self-clear, read-only, reset zero
// - config bit selects long or short reset
// - restart bit clears timers; host sets then clears
// - fast timer enable bit, reset disabled
// - status read latches and acknowledges set bits
// - two-bit code selects charge current fraction
// - usb allowed bit and usb current limit
// - charge enable, adapter preferred over usb
// ----------------------------------------------------------------
module csir_regs #(
    parameter int unsigned POR_LONG_CYCLES = csir_pkg::POR_LONG_CYCLES,
    parameter int unsigned POR_SHORT_CYCLES = csir_pkg::POR_SHORT_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    // register access from the serial engine
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rdata_valid,
    // charger conditions
    input wire logic usb_valid,
    input wire logic adapter_valid,
    input wire logic thermal_suspend,
    input wire logic term_current,
    input wire logic taper_timeout,
    input wire logic fast_charge_timeout,
    input wire logic precharge_timeout,
    input wire logic battery_temperature_fault,
    // regulator conditions
    input wire logic power_button_request,
    input wire logic battery_lid_sense_n,
    input wire logic supply_undervoltage,
    input wire logic linear_regulator_b_bad,
    input wire logic linear_regulator_b_enable,
    input wire logic linear_regulator_a_bad,
    input wire logic linear_regulator_a_enable,
    input wire logic main_converter_bad,
    input wire logic core_converter_bad,
    input wire logic low_power_mode,
    input wire logic core_off_in_low_power,
    // power-on reset request
    input wire logic power_on_request,
    // interrupt pin, open drain
    output logic int_pin_o,
    output logic int_pin_oe_n,
    // charger controls
    output logic charger_restart,
    output logic charger_force_reset,
    output logic fast_timer_enable,
    output logic [1:0] charge_current_code,
    output logic [2:0] charge_current_quarters,
    output logic usb_charge_allowed,
    output logic usb_limit_500ma,
    output logic charge_from_adapter,
    output logic charge_from_usb,
    output logic power_on_reset_n
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] chg_sync1;
        logic [7:0] chg_sync2;
        logic [7:0] chg_prev;
        logic [7:0] reg_sync1;
        logic [7:0] reg_sync2;
        logic [7:0] reg_prev;
        logic por_sync1;
        logic por_sync2;
        logic por_prev;
        logic [7:0] charge_status;
        logic [7:0] regulator_status;
        logic [7:0] charge_irq_mask;
        logic [7:0] regulator_irq_mask;
        logic [7:0] charge_irq_acknowledge;
        logic [7:0] regulator_irq_acknowledge;
        logic [7:0] charger_configuration;
        logic [7:0] rdata;
        logic rvalid;
        logic int_active;
        logic force_reset;
        logic [csir_pkg::POR_COUNT_W-1:0] por_count;
        logic por_active;
    } csir_state_t;

    csir_state_t state_reg;
    csir_state_t state_next;
    logic [7:0] chg_raw;
    logic [7:0] reg_raw;

    // condition vectors in register bit order
    assign chg_raw = {usb_valid, adapter_valid, thermal_suspend,
        term_current, taper_timeout, fast_charge_timeout,
        precharge_timeout, battery_temperature_fault};
    assign reg_raw = {power_button_request, ~battery_lid_sense_n,
        supply_undervoltage, 1'b0,
        linear_regulator_b_bad & linear_regulator_b_enable,
        linear_regulator_a_bad & linear_regulator_a_enable,
        main_converter_bad,
        core_converter_bad
            | (low_power_mode & core_off_in_low_power)};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] chg_rise;
        logic [7:0] reg_rise;
        logic [7:0] chg_hold;
        logic [7:0] reg_hold;
        logic [7:0] chg_rdack;
        logic [7:0] reg_rdack;
        logic [7:0] chg_wclr;
        logic chg_rd;
        logic reg_rd_hit;
        chg_rise = 8'h00;
        reg_rise = 8'h00;
        chg_hold = 8'h00;
        reg_hold = 8'h00;
        chg_rdack = 8'h00;
        reg_rdack = 8'h00;
        chg_wclr = 8'h00;
        chg_rd = reg_rd && (reg_addr == csir_pkg::CHARGE_STATUS_OFS);
        reg_rd_hit = reg_rd && (reg_addr == csir_pkg::REGULATOR_STATUS_OFS);
        state_next = state_reg;
        // synchronisers: pins are asynchronous to clk
        state_next.chg_sync1 = chg_raw;
        state_next.chg_sync2 = state_reg.chg_sync1;
        state_next.chg_prev = state_reg.chg_sync2;
        state_next.reg_sync1 = reg_raw;
        state_next.reg_sync2 = state_reg.reg_sync1;
        state_next.reg_prev = state_reg.reg_sync2;
        state_next.por_sync1 = power_on_request;
        state_next.por_sync2 = state_reg.por_sync1;
        state_next.por_prev = state_reg.por_sync2;
        chg_rise = state_reg.chg_sync2 & ~state_reg.chg_prev;
        reg_rise = state_reg.reg_sync2 & ~state_reg.reg_prev;

        // edge bits clear only once low and already acknowledged
        chg_hold = state_reg.charge_status
            & ~(~state_reg.chg_sync2 & state_reg.charge_irq_acknowledge);
        reg_hold = state_reg.regulator_status
            & ~(~state_reg.reg_sync2 & state_reg.regulator_irq_acknowledge);

        // host write of zero only drops timeout/termination bits whose
        // condition is already low; a live condition wins the same cycle
        if (reg_wr && reg_addr == csir_pkg::CHARGE_STATUS_OFS) begin
            chg_wclr = csir_pkg::CHG_WRITABLE_BITS & ~reg_wdata;
        end
        state_next.charge_status =
            (csir_pkg::CHG_EDGE_BITS & (chg_rise | chg_hold))
            | (~csir_pkg::CHG_EDGE_BITS & state_reg.chg_sync2
               & ~(chg_wclr & ~state_reg.chg_sync2));
        state_next.regulator_status = ~csir_pkg::REG_UNUSED_BIT & (
            (csir_pkg::REG_EDGE_BITS & (reg_rise | reg_hold))
            | (~csir_pkg::REG_EDGE_BITS & state_reg.reg_sync2));

        // a read acknowledges exactly what it returns
        if (chg_rd) begin
            chg_rdack = state_reg.charge_status;
        end
        if (reg_rd_hit) begin
            reg_rdack = state_reg.regulator_status;
        end
        state_next.charge_irq_acknowledge =
            (state_reg.charge_irq_acknowledge | chg_rdack)
            & state_next.charge_status;
        state_next.regulator_irq_acknowledge =
            (state_reg.regulator_irq_acknowledge | reg_rdack)
            & state_next.regulator_status;

        // writable registers; acknowledges are not writable
        state_next.force_reset = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                csir_pkg::CHARGE_STATUS_OFS: begin
                    state_next.force_reset = 1'b1;
                end
                csir_pkg::CHARGE_IRQ_MASK_OFS: begin
                    state_next.charge_irq_mask = reg_wdata;
                end
                csir_pkg::REGULATOR_IRQ_MASK_OFS: begin
                    // unused position stays at its reset one
                    state_next.regulator_irq_mask =
                        reg_wdata | csir_pkg::REG_UNUSED_BIT;
                end
                csir_pkg::CHARGER_CONFIG_OFS: begin
                    state_next.charger_configuration = reg_wdata;
                end
                default: begin
                end
            endcase
        end

        // read port
        state_next.rvalid = reg_rd;
        if (reg_rd) begin
            case (reg_addr)
                csir_pkg::CHARGE_STATUS_OFS:
                    state_next.rdata = state_reg.charge_status;
                csir_pkg::REGULATOR_STATUS_OFS:
                    state_next.rdata = state_reg.regulator_status;
                csir_pkg::CHARGE_IRQ_MASK_OFS:
                    state_next.rdata = state_reg.charge_irq_mask;
                csir_pkg::REGULATOR_IRQ_MASK_OFS:
                    state_next.rdata = state_reg.regulator_irq_mask;
                csir_pkg::CHARGE_IRQ_ACK_OFS:
                    state_next.rdata = state_reg.charge_irq_acknowledge;
                csir_pkg::REGULATOR_IRQ_ACK_OFS:
                    state_next.rdata = state_reg.regulator_irq_acknowledge;
                csir_pkg::CHARGER_CONFIG_OFS:
                    state_next.rdata = state_reg.charger_configuration;
                default:
                    state_next.rdata = csir_pkg::UNMAPPED_READ;
            endcase
        end

        // interrupt from the next status so the pin tracks in step
        state_next.int_active =
            |(state_next.charge_status & ~state_next.charge_irq_mask
              & ~state_next.charge_irq_acknowledge)
            | |(state_next.regulator_status & ~state_next.regulator_irq_mask
              & ~state_next.regulator_irq_acknowledge);

        // reset pulse, length picked when the request arrives
        if (state_reg.por_sync2 && !state_reg.por_prev) begin
            state_next.por_active = 1'b1;
            if (state_reg.charger_configuration[csir_pkg::CFG_POR_SEL]) begin
                state_next.por_count =
                    csir_pkg::POR_COUNT_W'(POR_SHORT_CYCLES - 1);
            end else begin
                state_next.por_count =
                    csir_pkg::POR_COUNT_W'(POR_LONG_CYCLES - 1);
            end
        end else if (state_reg.por_active) begin
            if (state_reg.por_count == '0) begin
                state_next.por_active = 1'b0;
            end else begin
                state_next.por_count = state_reg.por_count - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
            state_reg.charge_status <= csir_pkg::STATUS_RESET;
            state_reg.regulator_status <= csir_pkg::STATUS_RESET;
            state_reg.charge_irq_mask <= csir_pkg::MASK_RESET;
            state_reg.regulator_irq_mask <= csir_pkg::MASK_RESET;
            state_reg.charge_irq_acknowledge <= csir_pkg::ACK_RESET;
            state_reg.regulator_irq_acknowledge <= csir_pkg::ACK_RESET;
            state_reg.charger_configuration <= csir_pkg::CONFIG_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // pin driven low (enable low) only when pending; never driven high
    assign int_pin_o = 1'b0;
    assign int_pin_oe_n = ~state_reg.int_active;
    assign reg_rdata = state_reg.rdata;
    assign reg_rdata_valid = state_reg.rvalid;
    assign charger_force_reset = state_reg.force_reset;
    assign power_on_reset_n = ~state_reg.por_active;
    // restart is a level; host owns the set-then-clear sequence
    assign charger_restart =
        state_reg.charger_configuration[csir_pkg::CFG_RESTART];
    assign fast_timer_enable =
        state_reg.charger_configuration[csir_pkg::CFG_FAST_TIMER];
    assign charge_current_code = state_reg.charger_configuration[
        csir_pkg::CFG_CURRENT_MSB:csir_pkg::CFG_CURRENT_LSB];
    // quarters of full current: code 0 gives 1/4, code 3 gives 4/4
    assign charge_current_quarters = {1'b0, charge_current_code}
        + 3'h1;
    assign usb_charge_allowed =
        state_reg.charger_configuration[csir_pkg::CFG_USB_ALLOWED];
    assign usb_limit_500ma = usb_charge_allowed
        & state_reg.charger_configuration[csir_pkg::CFG_USB_500];
    // adapter wins when both sources are valid
    assign charge_from_adapter =
        state_reg.charger_configuration[csir_pkg::CFG_CHARGE_EN]
        & state_reg.charge_status[6];
    assign charge_from_usb =
        state_reg.charger_configuration[csir_pkg::CFG_CHARGE_EN]
        & usb_charge_allowed & state_reg.charge_status[7]
        & ~state_reg.charge_status[6];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_usb_flag_follows: assert property (
        state_reg.chg_sync2[7] |=> state_reg.charge_status[7])
        else $error("usb flag not set while source valid");
    a_adapter_flag_clear: assert property (
        !state_reg.chg_sync2[6] |=> !state_reg.charge_status[6])
        else $error("adapter flag stays set without source");
    a_unused_bit_zero: assert property (
        !state_reg.regulator_status[4] && state_reg.regulator_irq_mask[4]
        && !state_reg.regulator_irq_acknowledge[4])
        else $error("regulator bit four is not idle");
    a_mask_reset_ones: assert property (
        $rose(reset_n) |-> state_reg.charge_irq_mask == 8'hff)
        else $error("charge mask not all ones after reset");
    a_read_acks_status: assert property (
        (reg_rd && reg_addr == csir_pkg::CHARGE_STATUS_OFS
         && state_reg.chg_sync2 == state_reg.chg_prev
         && state_reg.chg_sync1 == state_reg.chg_sync2)
        |=> ((state_reg.charge_irq_acknowledge | ~state_reg.charge_status)
             & $past(state_reg.charge_status)) == $past(state_reg.charge_status))
        else $error("read did not acknowledge set bits");
    a_read_data_latched: assert property (
        reg_rd && reg_addr == csir_pkg::REGULATOR_STATUS_OFS
        |=> reg_rdata_valid && reg_rdata == $past(state_reg.regulator_status))
        else $error("regulator status read data wrong");
    a_ack_self_clear: assert property (
        !state_reg.charge_status[3] |-> !state_reg.charge_irq_acknowledge[3])
        else $error("acknowledge held without status");
    a_int_pin_pending: assert property (
        (state_reg.charge_status[0] && !state_reg.charge_irq_mask[0]
         && !state_reg.charge_irq_acknowledge[0]) |-> !int_pin_oe_n)
        else $error("unmasked charge bit does not drive pin");
    a_int_pin_idle: assert property (
        (state_reg.charge_status == 8'h00 && state_reg.regulator_status == 8'h00)
        |-> int_pin_oe_n)
        else $error("pin driven with nothing pending");
    a_pb_edge_set: assert property (
        state_reg.reg_sync2[7] && !state_reg.reg_prev[7]
        |=> state_reg.regulator_status[7] [*2])
        else $error("button press not captured");
    a_usb_limit_gate: assert property (
        !usb_charge_allowed |-> !usb_limit_500ma && !charge_from_usb)
        else $error("usb charging used while disallowed");
    a_adapter_preferred: assert property (
        charge_from_adapter |-> !charge_from_usb)
        else $error("both sources chosen together");

    c_read_ack: cover property (
        reg_rd && reg_addr == csir_pkg::CHARGE_STATUS_OFS
        && state_reg.charge_status != 8'h00 ##1 int_pin_oe_n);
    c_int_asserted: cover property ($fell(int_pin_oe_n));
    c_por_pulse: cover property ($fell(power_on_reset_n));
    c_status_write: cover property (charger_force_reset);

endmodule // csir_regs

// ==== tb/csir_host_model.sv ====
// host side model driving the register port of the status block
`timescale 1ns/1ps
module csir_host_model (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rdata_valid
);
    // idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end

    // one-cycle write strobe; released data shows the inverse, not the old byte
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // one-cycle read strobe; answer sampled in the cycle it stands
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                            output logic ok);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        ok = reg_rdata_valid;
        d = reg_rdata;
    endtask
endmodule // csir_host_model

// ==== tb/charger_status_interrupt_regs_test.sv ====
// self-checking bench for the charger status and interrupt registers
`timescale 1ns/1ps
module charger_status_interrupt_regs_test;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, rvalid;
    logic [7:0] chg = 8'h00;
    logic pb = 0, lid_n = 1, uv = 0, lb_bad = 0, lb_en = 0, la_bad = 0;
    logic la_en = 0, mn_bad = 0, cr_bad = 0, lp = 0, cr_off = 0, por_req = 0;
    logic int_o, int_oe_n, restart, frc, fast_en, usb_ok, usb500, from_ac;
    logic from_usb, por_n;
    logic [1:0] cur_code;
    logic [2:0] quarters;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    always #4 clk = ~clk;

    csir_host_model i_host (.clk(clk), .reg_addr(addr), .reg_wr(wr),
        .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata),
        .reg_rdata_valid(rvalid));

    // short reset pulse counts keep the run brief
    csir_regs #(.POR_LONG_CYCLES(20), .POR_SHORT_CYCLES(5)) i_dut (
        .clk(clk), .reset_n(reset_n), .reg_addr(addr), .reg_wr(wr),
        .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata),
        .reg_rdata_valid(rvalid), .usb_valid(chg[7]),
        .adapter_valid(chg[6]), .thermal_suspend(chg[5]),
        .term_current(chg[4]), .taper_timeout(chg[3]),
        .fast_charge_timeout(chg[2]), .precharge_timeout(chg[1]),
        .battery_temperature_fault(chg[0]), .power_button_request(pb),
        .battery_lid_sense_n(lid_n), .supply_undervoltage(uv),
        .linear_regulator_b_bad(lb_bad), .linear_regulator_b_enable(lb_en),
        .linear_regulator_a_bad(la_bad), .linear_regulator_a_enable(la_en),
        .main_converter_bad(mn_bad), .core_converter_bad(cr_bad),
        .low_power_mode(lp), .core_off_in_low_power(cr_off),
        .power_on_request(por_req), .int_pin_o(int_o),
        .int_pin_oe_n(int_oe_n), .charger_restart(restart),
        .charger_force_reset(frc), .fast_timer_enable(fast_en),
        .charge_current_code(cur_code), .charge_current_quarters(quarters),
        .usb_charge_allowed(usb_ok), .usb_limit_500ma(usb500),
        .charge_from_adapter(from_ac), .charge_from_usb(from_usb),
        .power_on_reset_n(por_n));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        i_host.read_reg(a, d, ok);
        check({7'h00, ok}, 8'h01, "read valid");
        check(d, exp, $sformatf("read %h", a));
    endtask

    // settle past the two-flop input synchroniser before looking
    task automatic settle();
        repeat (5) @(posedge clk);
        #1;
    endtask

    task automatic pin(input logic exp);
        check({7'h00, int_oe_n}, {7'h00, exp}, "interrupt pin enable");
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] tab [8] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00,
                               8'h1b, 8'hff};
        for (int i = 0; i < 8; i++) begin
            rd_chk(8'(i + 1), tab[i]);
        end
        pin(1'b1);
        check({7'h00, int_o}, 8'h00, "pin data");
        check({5'h00, quarters}, 8'h04, "reset current");
        $display("test reset done");
    endtask

    task automatic t_charge();
        chg <= 8'h80;
        settle();
        pin(1'b1);
        i_host.write_reg(8'h03, 8'h00);
        #1;
        pin(1'b0);
        check({7'h00, from_usb}, 8'h01, "usb source");
        i_host.write_reg(8'h07, 8'h19);
        #1;
        check({7'h00, from_usb}, 8'h00, "usb barred");
        i_host.write_reg(8'h07, 8'h1b);
        rd_chk(8'h01, 8'h80);
        pin(1'b1);
        rd_chk(8'h05, 8'h80);
        chg <= 8'hc0;
        settle();
        pin(1'b0);
        check({6'h00, from_ac, from_usb}, 8'h02, "adapter wins");
        i_host.write_reg(8'h05, 8'hff);
        rd_chk(8'h05, 8'h80);
        rd_chk(8'h01, 8'hc0);
        i_host.write_reg(8'h01, 8'h00);
        #1;
        check({7'h00, frc}, 8'h01, "force reset");
        rd_chk(8'h01, 8'hc0);
        chg <= 8'h00;
        settle();
        rd_chk(8'h05, 8'h00);
        rd_chk(8'h01, 8'h00);
        i_host.write_reg(8'h03, 8'hff);
        $display("test charge interrupt done");
    endtask

    task automatic t_regulator();
        i_host.write_reg(8'h04, 8'h00);
        rd_chk(8'h04, 8'h10);
        la_bad <= 1'b1;
        settle();
        pin(1'b1);
        la_en <= 1'b1;
        settle();
        pin(1'b0);
        rd_chk(8'h02, 8'h04);
        pin(1'b1);
        lp <= 1'b1;
        cr_off <= 1'b1;
        pb <= 1'b1;
        uv <= 1'b1;
        settle();
        pb <= 1'b0;
        uv <= 1'b0;
        settle();
        pin(1'b0);
        rd_chk(8'h02, 8'ha5);
        repeat (3) @(posedge clk);
        rd_chk(8'h06, 8'h05);
        la_bad <= 1'b0;
        lp <= 1'b0;
        settle();
        rd_chk(8'h06, 8'h00);
        i_host.write_reg(8'h02, 8'hff);
        rd_chk(8'h02, 8'h00);
        i_host.write_reg(8'h04, 8'hff);
        $display("test regulator interrupt done");
    endtask

    task automatic t_config();
        int len;
        for (int i = 0; i < 4; i++) begin
            i_host.write_reg(8'h07, {3'b000, 2'(i), 3'b011});
            #1;
            check({5'h00, quarters}, 8'(i + 1), "current fraction");
            check({6'h00, cur_code}, 8'(i), "current code");
        end
        i_host.write_reg(8'h07, 8'h47);
        #1;
        check({6'h00, restart, usb500}, 8'h03, "restart set");
        i_host.write_reg(8'h07, 8'h25);
        #1;
        check({3'h0, restart, fast_en, usb_ok, usb500, from_usb}, 8'h08,
              "timer and usb");
        for (int k = 0; k < 2; k++) begin
            i_host.write_reg(8'h07, k ? 8'h9b : 8'h1b);
            @(posedge clk);
            por_req <= 1'b1;
            len = 0;
            for (int w = 0; w < 10 && por_n !== 1'b0; w++) @(posedge clk) #1;
            while (por_n === 1'b0 && len < 100) begin
                @(posedge clk) #1;
                len++;
            end
            por_req <= 1'b0;
            check(8'(len), k ? 8'd5 : 8'd20, "reset pulse");
            settle();
        end
        $display("test configuration done");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // hang guard well above the fewer than two hundred cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            num_errors++;
            $display("MISMATCH t=%0t run timed out", $time);
            report_and_stop();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_charge();
        t_regulator();
        t_config();
        report_and_stop();
    end
endmodule // charger_status_interrupt_regs_test
